// file: hw/fic_top.sv
// flash command interface: feed unlock, configuration, command sequencer and register port
// ============================================================
// How it works
// R1: two write-only feed registers, reset to zero, unlock the next command
// R2: completion flag reads zero for an ignored command, one once finished
// R3: enable bit low ignores every command; high lets them execute
// R4: boot flag set when both port-1 bits 0 and 1 are low at reset
// R5: readback index in configuration picks what the status readback register returns
// R6: seven-bit command code, top bit reserved; 01 chip erase, 0d partition erase
// R7: code 0c verifies a byte by reading back, 0e programs one byte
// R8: code 03 secures a page; high address 90 locks page 0
// R9: software issues only defined codes; others are treated as ignored here
// R10: low address register pairs with high address byte to address the flash
// R11: an ignored command never reaches the flash array
`timescale 1ns/1ns
`default_nettype none
`include "fic_defs.svh"
module fic_top #(
	parameter int ADDR_W = 8                        // register address width
) (
	input  wire logic                  clk,          // core clock, 100 MHz
	input  wire logic                  reset,        // asynchronous, active high
	input  wire logic [ADDR_W-1:0]     reg_addr,     // register address
	input  wire logic [7:0]            reg_wdata,    // write data
	input  wire logic                  reg_wr,       // write strobe
	input  wire logic                  reg_rd,       // read strobe
	output logic [7:0]                 reg_rdata,    // read data, cycle after strobe
	input  wire logic [1:0]            boot_pins,    // port-1 bits 1:0
	output fic_pkg::fic_flash_req_t    flash_req,    // request to the array
	output logic                       flash_start,  // one-cycle start pulse
	input  wire logic                  flash_done,   // array finished
	input  wire logic [7:0]            flash_rdata,  // byte read by a verify
	output logic [2:0]                 clk_option,   // enable, relation, input select
	output logic                       irq           // level interrupt
);
	// ============================================================
	// parameter check
	if (ADDR_W < 8) begin : g_bad_width
		$error("fic_top: ADDR_W must be at least 8");
	end

	// ============================================================
	// declarations
	logic [7:0]             feed_first_r;
	logic [7:0]             feed_second_r;
	logic                   enable_r;
	logic                   done_flag_r;
	logic                   boot_flag_r;
	logic                   boot_taken_r;
	logic [2:0]             index_r;
	logic [6:0]             command_r;
	logic [7:0]             addr_low_r;
	logic [7:0]             addr_high_r;
	logic [7:0]             data_r;
	logic [7:0]             verify_r;
	logic                   page0_lock_r;
	logic [1:0]             evt_r;
	logic [1:0]             mask_r;
	logic [7:0]             rdata_r;
	logic                   irq_r;
	logic                   start_r;
	fic_pkg::fic_flash_req_t req_r;
	fic_pkg::fic_state_t    state_r;
	logic [7:0]             ofs;
	logic                   cmd_wr;
	logic                   unlocked;
	logic                   code_ok;
	logic                   accept;
	logic                   ignore;
	logic                   finish;
	logic [1:0]             evt_set;
	logic [1:0]             evt_clr;

	assign ofs      = reg_addr[7:0];
	assign cmd_wr   = reg_wr && (ofs == `FIC_OFS_COMMAND);
	// R1 feed keys unlock
	assign unlocked = (feed_first_r == `FIC_FEED_KEY_FIRST) && (feed_second_r == `FIC_FEED_KEY_SECOND);
	// R9 undefined codes and non-page-0 security targets are ignored
	always_comb begin
		unique case (reg_wdata[6:0])
			7'(fic_pkg::FIC_CMD_CHIP_ERASE),
			7'(fic_pkg::FIC_CMD_PART0_ERASE),
			7'(fic_pkg::FIC_CMD_BYTE_VERIFY),
			7'(fic_pkg::FIC_CMD_BYTE_PROG):   code_ok = 1'b1;
			7'(fic_pkg::FIC_CMD_SECURE_PAGE): code_ok = (addr_high_r == `FIC_SEC_PAGE0_HIGH);
			default:                          code_ok = 1'b0;
		endcase
	end
	// R3 enable gates acceptance; busy commands are ignored too
	assign accept = cmd_wr && enable_r && unlocked && code_ok && (state_r == fic_pkg::FIC_ST_IDLE);
	assign ignore = cmd_wr && !accept;
	assign finish = (state_r == fic_pkg::FIC_ST_BUSY) && flash_done;

	// ============================================================
	// feed registers, write only; consumed by every command write
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			feed_first_r  <= `FIC_RST_FEED;
			feed_second_r <= `FIC_RST_FEED;
		end else if (cmd_wr) begin
			// R1 one unlock per command attempt
			feed_first_r  <= `FIC_RST_FEED;
			feed_second_r <= `FIC_RST_FEED;
		end else if (reg_wr) begin
			if (ofs == `FIC_OFS_FEED_FIRST)
				feed_first_r <= reg_wdata;
			if (ofs == `FIC_OFS_FEED_SECOND)
				feed_second_r <= reg_wdata;
		end
	end

	// ============================================================
	// configuration: enable bit and readback index
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			enable_r <= `FIC_RST_ENABLE;
			index_r  <= 3'h0;
		end else if (reg_wr && ofs == `FIC_OFS_CFG_STATUS) begin
			enable_r <= reg_wdata[`FIC_CFG_ENABLE_BIT];
			index_r  <= reg_wdata[`FIC_CFG_INDEX_MSB:0];
		end
	end

	// R2 completion flag follows the last command outcome
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			done_flag_r <= 1'b0;
		else if (ignore)
			done_flag_r <= 1'b0;
		else if (finish)
			done_flag_r <= 1'b1;
	end

	// R4 boot pins caught at the first edge after reset release
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			boot_taken_r <= 1'b0;
			boot_flag_r  <= 1'b0;
		end else if (!boot_taken_r) begin
			boot_taken_r <= 1'b1;
			boot_flag_r  <= (boot_pins == 2'b00);
		end
	end

	// ============================================================
	// address, data, command and clock option registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			addr_low_r  <= 8'h00;
			addr_high_r <= 8'h00;
			data_r      <= 8'h00;
			command_r   <= `FIC_RST_COMMAND;
			clk_option  <= `FIC_RST_CLK_OPTION;
		end else if (reg_wr) begin
			// R10 low byte pairs with the high byte
			if (ofs == `FIC_OFS_ADDR_LOW)
				addr_low_r <= reg_wdata;
			if (ofs == `FIC_OFS_ADDR_HIGH)
				addr_high_r <= reg_wdata;
			if (ofs == `FIC_OFS_DATA)
				data_r <= reg_wdata;
			// R6 top bit reserved, not stored
			if (ofs == `FIC_OFS_COMMAND)
				command_r <= reg_wdata[6:0];
			if (ofs == `FIC_OFS_CLK_OPTION)
				clk_option <= reg_wdata[2:0];
		end
	end

	// ============================================================
	// sequencer: one command in flight, waits for the array
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			state_r <= fic_pkg::FIC_ST_IDLE;
		else begin
			unique case (state_r)
				fic_pkg::FIC_ST_IDLE: if (accept) state_r <= fic_pkg::FIC_ST_BUSY;
				fic_pkg::FIC_ST_BUSY: if (flash_done) state_r <= fic_pkg::FIC_ST_IDLE;
				default:              state_r <= fic_pkg::FIC_ST_IDLE;
			endcase
		end
	end

	// R11 the array sees a start only for accepted commands
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			start_r <= 1'b0;
			req_r   <= '0;
		end else begin
			start_r <= accept;
			if (accept) begin
				// R6 R7 R8 code and address passed to the array
				req_r.op    <= reg_wdata[6:0];
				req_r.addr  <= {addr_high_r, addr_low_r};
				req_r.wdata <= data_r;
			end
		end
	end

	// R7 verify captures the byte read back; R8 page 0 lock is sticky
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			verify_r     <= 8'h00;
			page0_lock_r <= 1'b0;
		end else if (finish) begin
			if (req_r.op == 7'(fic_pkg::FIC_CMD_BYTE_VERIFY))
				verify_r <= flash_rdata;
			if (req_r.op == 7'(fic_pkg::FIC_CMD_SECURE_PAGE))
				page0_lock_r <= 1'b1;
		end
	end

	// ============================================================
	// events: set wins over the read that clears
	assign evt_set = {ignore, finish};
	assign evt_clr = (reg_rd && ofs == `FIC_OFS_EVT_STATUS) ? 2'b11 : 2'b00;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			evt_r  <= 2'b00;
			mask_r <= 2'b00;
			irq_r  <= 1'b0;
		end else begin
			evt_r <= (evt_r & ~evt_clr) | evt_set;
			if (reg_wr && ofs == `FIC_OFS_EVT_MASK)
				mask_r <= reg_wdata[1:0];
			irq_r <= |(((evt_r & ~evt_clr) | evt_set) & mask_r);
		end
	end

	// ============================================================
	// read port; feed registers read as zero, unmapped reads zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			rdata_r <= 8'h00;
		else if (reg_rd) begin
			unique case (ofs)
				`FIC_OFS_CFG_STATUS: rdata_r <= {done_flag_r, enable_r, 1'b0, boot_flag_r, 1'b0, index_r};
				`FIC_OFS_COMMAND:    rdata_r <= {1'b0, command_r};
				`FIC_OFS_ADDR_LOW:   rdata_r <= addr_low_r;
				`FIC_OFS_ADDR_HIGH:  rdata_r <= addr_high_r;
				`FIC_OFS_DATA:       rdata_r <= data_r;
				`FIC_OFS_EVT_STATUS: rdata_r <= {6'h00, evt_r};
				`FIC_OFS_EVT_MASK:   rdata_r <= {6'h00, mask_r};
				`FIC_OFS_CLK_OPTION: rdata_r <= {5'h00, clk_option};
				// R5 index selects the readback content
				`FIC_OFS_READBACK: begin
					unique case (index_r)
						`FIC_IDX_STATE:    rdata_r <= {6'h00, unlocked, state_r == fic_pkg::FIC_ST_BUSY};
						`FIC_IDX_VERIFY:   rdata_r <= verify_r;
						`FIC_IDX_SECURITY: rdata_r <= {7'h00, page0_lock_r};
						default:           rdata_r <= 8'h00;
					endcase
				end
				default:             rdata_r <= 8'h00;
			endcase
		end else
			rdata_r <= 8'h00;
	end

	assign reg_rdata   = rdata_r;
	assign irq         = irq_r;
	assign flash_start = start_r;
	assign flash_req   = req_r;

	// ============================================================
	// assertions
	sequence s_cmd_ok;
		cmd_wr && enable_r && unlocked && code_ok && state_r == fic_pkg::FIC_ST_IDLE;
	endsequence
	sequence s_start_next;
		##1 flash_start && flash_req.op == $past(reg_wdata[6:0]);
	endsequence

	property p_feed_clear;
		@(posedge clk) disable iff (reset) cmd_wr |=> feed_first_r == 8'h00 && feed_second_r == 8'h00;
	endproperty
	a_feed_clear: assert property (p_feed_clear) else $error("feed not cleared by command"); // R1

	property p_done_zero;
		@(posedge clk) disable iff (reset) ignore |=> !done_flag_r;
	endproperty
	a_done_zero: assert property (p_done_zero) else $error("ignored command left flag set"); // R2

	property p_done_one;
		@(posedge clk) disable iff (reset) finish |=> done_flag_r && state_r == fic_pkg::FIC_ST_IDLE;
	endproperty
	a_done_one: assert property (p_done_one) else $error("finished command not flagged"); // R2

	property p_disabled;
		@(posedge clk) disable iff (reset) (cmd_wr && !enable_r) |=> !flash_start;
	endproperty
	a_disabled: assert property (p_disabled) else $error("command ran while disabled"); // R3

	property p_accept;
		@(posedge clk) disable iff (reset) s_cmd_ok |-> s_start_next;
	endproperty
	a_accept: assert property (p_accept) else $error("accepted command not started"); // R6

	property p_boot;
		@(posedge clk) disable iff (reset) !boot_taken_r |=> boot_flag_r == ($past(boot_pins) == 2'b00);
	endproperty
	a_boot: assert property (p_boot) else $error("boot flag wrong"); // R4

	property p_index;
		@(posedge clk) disable iff (reset)
			(reg_rd && ofs == `FIC_OFS_READBACK && index_r == `FIC_IDX_VERIFY) |=> reg_rdata == $past(verify_r);
	endproperty
	a_index: assert property (p_index) else $error("readback ignores index"); // R5

	property p_verify;
		@(posedge clk) disable iff (reset)
			(finish && req_r.op == 7'h0c) |=> verify_r == $past(flash_rdata);
	endproperty
	a_verify: assert property (p_verify) else $error("verify byte not captured"); // R7

	property p_lock;
		@(posedge clk) disable iff (reset) (finish && req_r.op == 7'h03) |=> page0_lock_r;
	endproperty
	a_lock: assert property (p_lock) else $error("page 0 not locked"); // R8

	property p_addr;
		@(posedge clk) disable iff (reset) flash_start |-> flash_req.addr == $past({addr_high_r, addr_low_r});
	endproperty
	a_addr: assert property (p_addr) else $error("address bytes misordered"); // R10

	property p_no_touch;
		@(posedge clk) disable iff (reset) ignore |=> !flash_start ##1 !flash_start || $past(accept);
	endproperty
	a_no_touch: assert property (p_no_touch) else $error("ignored command reached the array"); // R11
endmodule // fic_top
`default_nettype wire

// file: pkg/fic_defs.svh
// offsets, field positions, reset values and keys of the flash command interface
`ifndef FIC_DEFS_SVH
`define FIC_DEFS_SVH
// ============================================================
// register offsets
`define FIC_OFS_FEED_FIRST   8'h97
`define FIC_OFS_CFG_STATUS   8'hb1
`define FIC_OFS_COMMAND      8'hb2
`define FIC_OFS_ADDR_LOW     8'hb3
`define FIC_OFS_ADDR_HIGH    8'hb4
`define FIC_OFS_READBACK     8'hb5
`define FIC_OFS_DATA         8'hb6
`define FIC_OFS_EVT_STATUS   8'hb8
`define FIC_OFS_EVT_MASK     8'hb9
`define FIC_OFS_CLK_OPTION   8'hbf
`define FIC_OFS_FEED_SECOND  8'hc4
// ============================================================
// configuration register fields
`define FIC_CFG_DONE_BIT     7
`define FIC_CFG_ENABLE_BIT   6
`define FIC_CFG_BOOT_BIT     4
`define FIC_CFG_INDEX_MSB    2
// reset values
`define FIC_RST_FEED         8'h00
`define FIC_RST_ENABLE       1'h1
`define FIC_RST_COMMAND      7'h00
`define FIC_RST_CLK_OPTION   3'h0
// ============================================================
// unlock keys expected in the two feed registers
`define FIC_FEED_KEY_FIRST   8'haa
`define FIC_FEED_KEY_SECOND  8'h55
// security target address for page 0
`define FIC_SEC_PAGE0_HIGH   8'h90
// readback index values
`define FIC_IDX_STATE        3'h0
`define FIC_IDX_VERIFY       3'h1
`define FIC_IDX_SECURITY     3'h2
// event status bits
`define FIC_EVT_DONE_BIT     0
`define FIC_EVT_IGNORED_BIT  1
`endif

// file: pkg/fic_pkg.sv
// types of the flash command interface
`default_nettype none
package fic_pkg;
	// command codes in the command register
	typedef enum logic [6:0] {
		FIC_CMD_CHIP_ERASE  = 7'h01,
		FIC_CMD_SECURE_PAGE = 7'h03,
		FIC_CMD_BYTE_VERIFY = 7'h0c,
		FIC_CMD_PART0_ERASE = 7'h0d,
		FIC_CMD_BYTE_PROG   = 7'h0e
	} fic_cmd_t;
	// sequencer states, one-hot
	typedef enum logic [1:0] {
		FIC_ST_IDLE = 2'b01,
		FIC_ST_BUSY = 2'b10
	} fic_state_t;
	// request handed to the flash array
	typedef struct packed {
		logic [6:0]  op;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} fic_flash_req_t;
endpackage : fic_pkg
`default_nettype wire

// file: sim/fic_top_tb_top.sv
// self-checking bench for the flash command interface
`timescale 1ns/1ns
`default_nettype none
`include "fic_defs.svh"
module fic_top_tb_top;
	logic                    clk;
	logic                    reset;
	logic [7:0]              reg_addr;
	logic [7:0]              reg_wdata;
	logic                    reg_wr;
	logic                    reg_rd;
	logic [7:0]              reg_rdata;
	logic [1:0]              boot_pins;
	fic_pkg::fic_flash_req_t flash_req;
	logic                    flash_start;
	logic                    flash_done;
	logic [7:0]              flash_rdata;
	logic [2:0]              clk_option;
	logic                    irq;
	logic [7:0]              rv;
	logic [7:0]              mask_v;
	int                      bad_count;
	int                      check_count;
	int                      cycles;

	// ============================================================
	// device under test
	fic_top #(.ADDR_W(8)) dut_u (
		.clk         (clk),
		.reset       (reset),
		.reg_addr    (reg_addr),
		.reg_wdata   (reg_wdata),
		.reg_wr      (reg_wr),
		.reg_rd      (reg_rd),
		.reg_rdata   (reg_rdata),
		.boot_pins   (boot_pins),
		.flash_req   (flash_req),
		.flash_start (flash_start),
		.flash_done  (flash_done),
		.flash_rdata (flash_rdata),
		.clk_option  (clk_option),
		.irq         (irq)
	);

	// 100 MHz core clock
	always #5 clk = ~clk;

	// ============================================================
	// shared tasks
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// one-cycle write strobe; a gap cycle follows so strobes never double up
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	// read data is only valid in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic do_reset(input logic [1:0] pins);
		boot_pins <= pins;
		reset     <= 1'b1;
		repeat (8) @(posedge clk);
		reset     <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// full command: address, data, optional unlock, command, array answer, status
	task automatic run_cmd(input logic [6:0] code, input logic [7:0] hi, input logic [7:0] lo,
		input logic [7:0] d, input logic feed, input logic ok);
		logic [6:0] prev_op;
		prev_op = flash_req.op;
		wr(`FIC_OFS_ADDR_LOW, lo);
		wr(`FIC_OFS_ADDR_HIGH, hi);
		wr(`FIC_OFS_DATA, d);
		if (feed) begin
			wr(`FIC_OFS_FEED_FIRST, `FIC_FEED_KEY_FIRST);
			wr(`FIC_OFS_FEED_SECOND, `FIC_FEED_KEY_SECOND);
		end
		wr(`FIC_OFS_COMMAND, {1'b0, code});
		#1;
		chk("start", {7'h00, flash_start}, {7'h00, ok});
		chk("op", {1'b0, flash_req.op}, {1'b0, (ok ? code : prev_op)});
		if (ok) begin
			chk("addr high", flash_req.addr[15:8], hi);
			chk("addr low", flash_req.addr[7:0], lo);
			chk("wdata", flash_req.wdata, d);
		end
		@(posedge clk);
		#1;
		chk("start pulse", {7'h00, flash_start}, 8'h00);
		// array answers only for a started command; the read byte is the inverse of the data
		@(posedge clk);
		flash_done  <= ok;
		flash_rdata <= ~d;
		@(posedge clk);
		flash_done  <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("irq", {7'h00, irq}, {7'h00, (ok ? mask_v[0] : mask_v[1])});
		rd(`FIC_OFS_CFG_STATUS, rv);
		chk("completion", {7'h00, rv[7]}, {7'h00, ok});
		rd(`FIC_OFS_COMMAND, rv);
		chk("command readback", rv, {1'b0, code});
		rd(`FIC_OFS_EVT_STATUS, rv);
		chk("events", rv, (ok ? 8'h01 : 8'h02));
		rd(`FIC_OFS_EVT_STATUS, rv);
		chk("events cleared", rv, 8'h00);
		repeat (2) @(posedge clk);
		#1;
		chk("irq low", {7'h00, irq}, 8'h00);
	endtask

	// ============================================================
	// hang guard: the whole run needs well under this many cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			$display("mismatch timeout expected 1 seen 0");
			tally_and_finish;
		end
	end

	// ============================================================
	// main sequence
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		boot_pins = 2'b00;
		flash_done = 1'b0;
		flash_rdata = 8'h00;
		mask_v = 8'h00;
		bad_count = 0;
		check_count = 0;
		cycles = 0;
		do_reset(2'b00);
		rd(`FIC_OFS_CFG_STATUS, rv);
		chk("cfg reset", rv, 8'h50);
		@(posedge clk);
		#1;
		chk("rdata idle", reg_rdata, 8'h00);
		rd(`FIC_OFS_FEED_FIRST, rv);
		chk("feed first reset", rv, 8'h00);
		rd(`FIC_OFS_FEED_SECOND, rv);
		chk("feed second reset", rv, 8'h00);
		rd(`FIC_OFS_COMMAND, rv);
		chk("command reset", rv, 8'h00);
		rd(`FIC_OFS_EVT_MASK, rv);
		chk("mask reset", rv, 8'h00);
		wr(`FIC_OFS_FEED_FIRST, `FIC_FEED_KEY_FIRST);
		rd(`FIC_OFS_FEED_FIRST, rv);
		chk("feed write only", rv, 8'h00);
		// index 0 shows the unlock state once both keys are in
		wr(`FIC_OFS_FEED_SECOND, `FIC_FEED_KEY_SECOND);
		rd(`FIC_OFS_READBACK, rv);
		chk("readback state", rv, 8'h02);
		rd(8'h00, rv);
		chk("unmapped", rv, 8'h00);
		$display("test reset_values done");
		wr(`FIC_OFS_CLK_OPTION, 8'h07);
		#1;
		chk("clk option", {5'h00, clk_option}, 8'h07);
		rd(`FIC_OFS_CLK_OPTION, rv);
		chk("clk option read", rv, 8'h07);
		wr(`FIC_OFS_CLK_OPTION, 8'h05);
		#1;
		chk("clk option two", {5'h00, clk_option}, 8'h05);
		$display("test clock_option done");
		// accepted commands, finished event unmasked
		mask_v = 8'h01;
		wr(`FIC_OFS_EVT_MASK, mask_v);
		run_cmd(fic_pkg::FIC_CMD_CHIP_ERASE, 8'h00, 8'h00, 8'h00, 1'b1, 1'b1);
		run_cmd(fic_pkg::FIC_CMD_PART0_ERASE, 8'h00, 8'h00, 8'h00, 1'b1, 1'b1);
		run_cmd(fic_pkg::FIC_CMD_BYTE_PROG, 8'h12, 8'h34, 8'ha5, 1'b1, 1'b1);
		run_cmd(fic_pkg::FIC_CMD_BYTE_VERIFY, 8'h12, 8'h34, 8'h5a, 1'b1, 1'b1);
		wr(`FIC_OFS_CFG_STATUS, 8'h41);
		rd(`FIC_OFS_READBACK, rv);
		chk("verify byte", rv, 8'ha5);
		run_cmd(fic_pkg::FIC_CMD_SECURE_PAGE, `FIC_SEC_PAGE0_HIGH, 8'h00, 8'h00, 1'b1, 1'b1);
		wr(`FIC_OFS_CFG_STATUS, 8'h42);
		rd(`FIC_OFS_READBACK, rv);
		chk("page0 lock", {7'h00, rv[0]}, 8'h01);
		wr(`FIC_OFS_CFG_STATUS, 8'h40);
		$display("test accepted_commands done");
		// refused commands, then one accepted after re-enable; ignored event unmasked
		mask_v = 8'h03;
		wr(`FIC_OFS_EVT_MASK, mask_v);
		run_cmd(fic_pkg::FIC_CMD_BYTE_PROG, 8'h22, 8'h44, 8'h66, 1'b0, 1'b0);
		run_cmd(7'h05, 8'h22, 8'h44, 8'h66, 1'b1, 1'b0);
		run_cmd(fic_pkg::FIC_CMD_SECURE_PAGE, 8'h91, 8'h00, 8'h00, 1'b1, 1'b0);
		wr(`FIC_OFS_CFG_STATUS, 8'h00);
		run_cmd(fic_pkg::FIC_CMD_BYTE_PROG, 8'h22, 8'h44, 8'h66, 1'b1, 1'b0);
		wr(`FIC_OFS_CFG_STATUS, 8'h40);
		run_cmd(fic_pkg::FIC_CMD_BYTE_PROG, 8'h22, 8'h44, 8'h66, 1'b1, 1'b1);
		$display("test refused_commands done");
		// second reset with only one boot pin low
		do_reset(2'b01);
		rd(`FIC_OFS_CFG_STATUS, rv);
		chk("cfg boot clear", rv, 8'h40);
		rd(`FIC_OFS_EVT_MASK, rv);
		chk("mask after reset", rv, 8'h00);
		$display("test second_reset done");
		tally_and_finish;
	end
endmodule // fic_top_tb_top
`default_nettype wire
